// ==== port_e_defs.vh ====
/*
 * constants for the port E function select block: register offset, field
 * positions, reset values per mode, mode codes and bus clock divide.
 * assumes it is included by bare name from the design files only.
 */
// Overview of operation
// RULE1: free-cycle select: first write only in normal, none in emulation, any in special.
// RULE2: free-cycle select 1 makes bit 7 I/O; 0 drives free-cycle indicator.
// RULE3: single-chip and peripheral modes: free-cycle, queue, read/write selects do nothing.
// RULE4: queue status select: write once normal, never emulation, anytime special.
// RULE5: queue status select 1 drives queue state on bits 6:5; 0 gives I/O.
// RULE6: bus clock disable writable anytime in normal and special, never in emulation.
// RULE7: disable 0 drives bus clock on bit 4, free-running while stretch is 0.
// RULE8: bus clock output available on bit 4 in every mode, single-chip too.
// RULE9: low strobe select: write once normal, never emulation, anytime special.
// RULE10: low strobe select 1 drives strobe; tagging samples low tag rising, strobe falling; the code takes the tag at the falling edge.
// RULE11: low strobe select ignored in single-chip, peripheral, normal expanded narrow modes.
// RULE12: after reset in normal expanded mode, low strobe and read/write stay disabled.
// RULE13: software should enable the low strobe before external writes needing it.
// RULE14: external reads proceed without the low strobe; all 16 data bits driven.
// RULE15: read/write select: write once normal, never emulation, anytime special; drives bit 2.
// RULE16: software should enable read/write output before writes to external writable resources.
// RULE17: pin given to a bus control function ignores its direction bit.
// RULE18: each write-once bit has a reset-cleared flag blocking later writes.
`ifndef PORT_E_DEFS_VH
`define PORT_E_DEFS_VH

// register map (byte addresses on the bus, byte address = 4 * index)
`define PE_SEL_ADDR        8'h28
`define PE_STATUS_ADDR     8'h2C

// field positions in the function select register
`define PE_FREE_BIT        7
`define PE_QUEUE_BIT       5
`define PE_CLKDIS_BIT      4
`define PE_LOW_BYTE_STROBE_BIT       3
`define PE_RW_BIT          2
`define PE_WMASK           8'hBC

// mode codes {c,b,a}
`define MODE_SPEC_SINGLE   3'h0
`define MODE_EMUL_NARROW   3'h1
`define MODE_SPEC_TEST     3'h2
`define MODE_EMUL_WIDE     3'h3
`define MODE_NORM_SINGLE   3'h4
`define MODE_NORM_NARROW   3'h5
`define MODE_PERIPHERAL    3'h6
`define MODE_NORM_WIDE     3'h7

// reset values of the function select register per mode
`define PE_RST_ZERO        8'h00
`define PE_RST_EMUL_TEST   8'h2C
`define PE_RST_NORM_SINGLE 8'h10
`define PE_RST_EMUL        8'hAC

// write policy codes
`define WPOL_NEVER         2'h0
`define WPOL_ONCE          2'h1
`define WPOL_ANY           2'h2

// terminal count of the bus clock divider; half period is this plus one system clock
`define BUS_CLK_HALF       4'h1

`endif

// ==== select_bit.v ====
/*
 * one select bit of the function register with its write policy.
 * assumes a write strobe qualified by the bus and a mode-derived policy.
 */
`timescale 1ns/1ns
`include "port_e_defs.vh"
module select_bit (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // reset value and write request
    input  wire       rst_val_i,
    input  wire [1:0] policy_i,
    input  wire       wr_i,
    input  wire       wdat_i,
    // state
    output wire       val_o,
    output wire       used_o
);
    reg  val_reg;
    reg  used_reg;
    wire allow;

    // once-policy honoured only while no write has landed
    assign allow = (policy_i == `WPOL_ANY) ||
                   ((policy_i == `WPOL_ONCE) && !used_reg);

    always @(posedge clk_i) begin
        if (rst_i) begin
            val_reg  <= rst_val_i;             // mode image, not counted as a write
            used_reg <= 1'b0;                  // [RULE18]
        end else if (used_reg == 1'b0 && policy_i == `WPOL_NEVER) begin
            val_reg  <= val_reg;
        end else if (wr_i && allow) begin
            val_reg  <= wdat_i;
            used_reg <= 1'b1;                  // [RULE18]
        end
    end

    assign val_o  = val_reg;
    assign used_o = used_reg;
endmodule

// ==== port_e_function_assignment.v ====
/*
 * port E pin function select: register over classic wishbone, write
 * policies per mode, and the pin mux for bits 7 and 6:2.
 * assumes mode strap is stable around reset and bus signals come from the
 * same clock; pin inputs from outside are synchronised here.
 */
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`include "port_e_defs.vh"
module port_e_function_assignment (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // wishbone slave
    input  wire       cyc_i,
    input  wire       stb_i,
    input  wire       we_i,
    input  wire [7:0] adr_i,
    input  wire [3:0] sel_i,
    input  wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire       ack_o,
    // operating mode strap and control
    input  wire [2:0] mode_i,
    input  wire       bus_clock_stretch_ctl_i,
    input  wire       tag_enable_i,
    // core bus status
    input  wire       free_cycle_i,
    input  wire [1:0] queue_state_i,
    input  wire       low_byte_strobe_i,
    input  wire       read_write_i,
    // general-purpose port data and direction
    input  wire [7:2] port_e_data_i,
    input  wire [7:2] port_e_direction_i,
    // pins
    input  wire [7:2] pin_i,
    output wire [7:2] pin_o,
    output wire [7:2] pin_oe_o,
    // captured low tag
    output wire       low_tag_input_o
);
    // bus registers
    reg  [31:0] dat_reg;
    reg         ack_reg;
    // mode caught after reset
    reg  [2:0]  mode_reg;
    reg         mode_valid_reg;
    // pin sync and outputs
    reg  [7:2]  sync1_reg;
    reg  [7:2]  sync2_reg;
    reg  [7:2]  pin_reg;
    reg  [7:2]  pin_next;
    reg  [7:2]  oe_reg;
    reg  [7:2]  oe_next;
    reg         tag_reg;
    // bus clock divider
    reg  [3:0]  div_reg;
    reg         external_bus_clock_reg;
    // pin 3 release state, delayed to line up with the synchroniser
    reg         rel1_reg;
    reg         rel2_reg;

    wire        emul_mode;
    wire        spec_mode;
    wire        single_mode;
    wire        periph_mode;
    wire        narrow_norm;
    wire [1:0]  pol_once;
    wire [1:0]  pol_clk;
    wire        wr_sel;
    wire [4:0]  wr_bits;
    wire [4:0]  rst_bits;
    wire [4:0]  val_bits;
    wire [4:0]  used_bits;
    wire [1:0]  pol_bits [4:0];
    wire [7:0]  sel_value;
    wire [7:0]  rst_value;
    wire        ctl_ok;
    wire        low_byte_strobe_ok;
    wire        sel_rst;
    wire [2:0]  mode_now;

    // mode classes
    assign emul_mode   = (mode_reg == `MODE_EMUL_NARROW) || (mode_reg == `MODE_EMUL_WIDE);
    assign spec_mode   = (mode_reg == `MODE_SPEC_SINGLE) || (mode_reg == `MODE_SPEC_TEST) ||
                         (mode_reg == `MODE_PERIPHERAL);
    assign single_mode = (mode_reg == `MODE_SPEC_SINGLE) || (mode_reg == `MODE_NORM_SINGLE);
    assign periph_mode = (mode_reg == `MODE_PERIPHERAL);
    assign narrow_norm = (mode_reg == `MODE_NORM_NARROW);

    // write policies per bit
    assign pol_once = emul_mode ? `WPOL_NEVER : (spec_mode ? `WPOL_ANY : `WPOL_ONCE); // [RULE1] [RULE4] [RULE9]
    assign pol_clk  = emul_mode ? `WPOL_NEVER : `WPOL_ANY;                            // [RULE6]
    assign pol_bits[4] = pol_once;   // free cycle
    assign pol_bits[3] = pol_once;   // queue status
    assign pol_bits[2] = pol_clk;    // bus clock disable
    assign pol_bits[1] = pol_once;   // low strobe
    assign pol_bits[0] = pol_once;   // read/write [RULE15]

    // reset value by mode, from the strap in the load cycle; normal expanded leaves strobes off [RULE12]
    assign mode_now  = mode_valid_reg ? mode_reg : mode_i;
    assign rst_value = (mode_now == `MODE_SPEC_TEST)   ? `PE_RST_EMUL_TEST :
                       ((mode_now == `MODE_EMUL_NARROW) || (mode_now == `MODE_EMUL_WIDE)) ? `PE_RST_EMUL :
                       (mode_now == `MODE_NORM_SINGLE) ? `PE_RST_NORM_SINGLE : `PE_RST_ZERO;
    assign rst_bits = {rst_value[`PE_FREE_BIT], rst_value[`PE_QUEUE_BIT], rst_value[`PE_CLKDIS_BIT],
                       rst_value[`PE_LOW_BYTE_STROBE_BIT], rst_value[`PE_RW_BIT]};

    // register write lands at the edge where the master sees ack, byte lane 0 carries the data
    assign wr_sel  = cyc_i && stb_i && we_i && ack_reg && sel_i[0] && (adr_i == `PE_SEL_ADDR);
    assign wr_bits = {dat_i[`PE_FREE_BIT], dat_i[`PE_QUEUE_BIT], dat_i[`PE_CLKDIS_BIT],
                      dat_i[`PE_LOW_BYTE_STROBE_BIT], dat_i[`PE_RW_BIT]};

    // bits stay in reset through the mode load cycle, so the image does not use up a write-once [RULE18]
    assign sel_rst = rst_i || !mode_valid_reg;
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_bit
            select_bit u_bit (
                .clk_i     (clk_i),
                .rst_i     (sel_rst),
                .rst_val_i (rst_bits[gi]),
                .policy_i  (pol_bits[gi]),
                .wr_i      (wr_sel),
                .wdat_i    (wr_bits[gi]),
                .val_o     (val_bits[gi]),
                .used_o    (used_bits[gi])
            );
        end
    endgenerate

    assign sel_value = {val_bits[4], 1'b0, val_bits[3], val_bits[2], val_bits[1], val_bits[0], 2'b00};

    // catch mode strap one cycle after reset release
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg       <= `MODE_SPEC_SINGLE;
            mode_valid_reg <= 1'b0;
        end else if (!mode_valid_reg) begin
            mode_reg       <= mode_i;
            mode_valid_reg <= 1'b1;
        end
    end

    // wishbone: ack one cycle after request, dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= cyc_i && stb_i && !ack_reg;
            if (adr_i == `PE_SEL_ADDR)
                dat_reg <= {24'h000000, sel_value};
            else if (adr_i == `PE_STATUS_ADDR)
                dat_reg <= {24'h000000, 1'b0, mode_reg, used_bits[4], used_bits[3], used_bits[1], used_bits[0]};
            else
                dat_reg <= 32'h00000000;           // unmapped reads zero
        end
    end

    // bus clock: free-running divider; stretch holds it high
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_reg    <= 4'h0;
            external_bus_clock_reg   <= 1'b0;
        end else begin
            if (div_reg == `BUS_CLK_HALF) begin
                div_reg <= 4'h0;
                if (!(bus_clock_stretch_ctl_i && external_bus_clock_reg))
                    external_bus_clock_reg <= ~external_bus_clock_reg;         // [RULE7]
            end else begin
                div_reg <= div_reg + 4'h1;
            end
        end
    end

    // pin input synchroniser
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
        end
    end

    // control selects act only in expanded modes [RULE3]; low strobe also off in narrow normal
    assign ctl_ok   = !single_mode && !periph_mode;
    assign low_byte_strobe_ok = ctl_ok && !narrow_norm;                // [RULE11]

    // pin mux; alternate functions override direction bits [RULE17]
    always @* begin
        pin_next = port_e_data_i;
        oe_next  = port_e_direction_i;
        if (ctl_ok && !val_bits[4]) begin                   // [RULE2]
            pin_next[7] = free_cycle_i;
            oe_next[7]  = 1'b1;
        end
        if (ctl_ok && val_bits[3]) begin                    // [RULE5]
            pin_next[6] = queue_state_i[1];
            pin_next[5] = queue_state_i[0];
            oe_next[6]  = 1'b1;
            oe_next[5]  = 1'b1;
        end
        if (!val_bits[2]) begin                             // [RULE8] any mode
            pin_next[4] = external_bus_clock_reg;
            oe_next[4]  = 1'b1;
        end
        if (low_byte_strobe_ok && val_bits[1]) begin                  // [RULE10]
            // tagging: release pin while clock high, drive strobe from falling edge
            pin_next[3] = low_byte_strobe_i;
            oe_next[3]  = !(tag_enable_i && external_bus_clock_reg);
        end
        if (ctl_ok && val_bits[0]) begin                    // [RULE15]
            pin_next[2] = read_write_i;
            oe_next[2]  = 1'b1;
        end
    end

    // registered pins; low tag taken at the end of each release window,
    // two cycles late since the pin reaches logic only through the synchroniser
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_reg  <= 6'h00;
            oe_reg   <= 6'h00;
            rel1_reg <= 1'b0;
            rel2_reg <= 1'b0;
            tag_reg  <= 1'b0;
        end else begin
            pin_reg  <= pin_next;
            oe_reg   <= oe_next;
            rel1_reg <= !oe_reg[3];
            rel2_reg <= rel1_reg;
            if (tag_enable_i && low_byte_strobe_ok && val_bits[1] && rel2_reg && !rel1_reg)
                tag_reg <= sync2_reg[3];                    // [RULE10]
        end
    end

    // reads need no strobe: data path is full width regardless [RULE14]
    assign dat_o           = dat_reg;
    assign ack_o           = ack_reg;
    assign pin_o           = pin_reg;
    assign pin_oe_o        = oe_reg;
    assign low_tag_input_o = tag_reg;
endmodule

// ==== port_e_far_side.sv ====
/* far side of port E: debug tag source on bit 3 and pull-ups.
   assumes the block drives a pin only while its enable is high. */
`timescale 1ns/1ns
module port_e_far_side (
    // block side
    input  wire [7:2] pin_o,
    input  wire [7:2] pin_oe_o,
    // debug tag source for bit 3
    input  wire       tag_drive_i,
    input  wire       tag_val_i,
    // resolved pin levels
    output wire [7:2] pin_i
);
    // released pins float to the pull-up, bit 3 to the tag value while the tag source drives
    for (genvar k = 2; k < 8; k++) begin : g_pin
        assign pin_i[k] = pin_oe_o[k] ? pin_o[k] : ((k == 3 && tag_drive_i) ? tag_val_i : 1'b1);
    end
endmodule

// ==== port_e_checker.sv ====
/* assertions on the port E function select block.
   assumes one clock and a bind onto the block top. */
`timescale 1ns/1ns
module port_e_checker (
    // clock, reset, bus
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    // mode and core status
    input wire [2:0]  mode_i,
    input wire        bus_clock_stretch_ctl_i,
    input wire        free_cycle_i,
    input wire [1:0]  queue_state_i,
    input wire        read_write_i,
    input wire [7:2]  port_e_direction_i,
    // pins
    input wire [7:2]  pin_o,
    input wire [7:2]  pin_oe_o
);
    logic [1:0] warm_reg;
    logic       bus_md;
    // hold off until the mode image has landed after reset
    always_ff @(posedge clk_i) begin
        if (rst_i)
            warm_reg <= 2'h0;
        else if (warm_reg != 2'h3)
            warm_reg <= warm_reg + 2'h1;
    end
    // selects act only outside single-chip and peripheral modes
    assign bus_md = (mode_i != 3'h0) && (mode_i != 3'h4) && (mode_i != 3'h6);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || warm_reg != 2'h3);
    sequence req_s; cyc_i && stb_i && !ack_o; endsequence
    sequence rd_s; ack_o && !we_i && adr_i == 8'h28; endsequence
    ack_once_a: assert property (req_s |=> ack_o ##1 !ack_o)
        else $error("ack not a single pulse");
    no_spur_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    emul_lock_a: assert property (rd_s and (!mode_i[2] && mode_i[0]) |-> dat_o[7:0] == 8'hAC)
        else $error("emulation select changed");
    gpio_keep_a: assert property (!bus_md && $stable(port_e_direction_i) |->
        {pin_oe_o[7:5], pin_oe_o[3:2]} == {port_e_direction_i[7:5], port_e_direction_i[3:2]})
        else $error("select acted in single-chip mode");
    free_pin_a: assert property (bus_md && pin_oe_o[7] && !$past(port_e_direction_i[7]) |->
        pin_o[7] == $past(free_cycle_i)) else $error("free cycle pin wrong");
    queue_pin_a: assert property (bus_md && pin_oe_o[6] && !$past(port_e_direction_i[6]) |->
        pin_o[6:5] == $past(queue_state_i)) else $error("queue pins wrong");
    rw_pin_a: assert property (bus_md && pin_oe_o[2] && !$past(port_e_direction_i[2]) |->
        pin_o[2] == $past(read_write_i)) else $error("read write pin wrong");
    clk_run_a: assert property (pin_oe_o[4] && !$past(port_e_direction_i[4]) && !bus_clock_stretch_ctl_i |->
        ##[1:4] ($changed(pin_o[4]) || !pin_oe_o[4])) else $error("bus clock stuck");
endmodule

bind port_e_function_assignment port_e_checker u_chk (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .mode_i, .bus_clock_stretch_ctl_i,
    .free_cycle_i, .queue_state_i, .read_write_i, .port_e_direction_i, .pin_o, .pin_oe_o);

// ==== port_e_function_assignment_tb.sv ====
/* self-checking bench for the port E function select block.
   assumes the far side model and the bound checker are compiled first. */
`timescale 1ns/1ns
module port_e_function_assignment_tb;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, bus_clock_stretch_ctl_i, tag_enable_i;
    logic        free_cycle_i, low_byte_strobe_i, read_write_i, low_tag_input_o, tag_val;
    logic [1:0]  queue_state_i;
    logic [2:0]  mode_i;
    logic [3:0]  sel_i;
    logic [7:0]  adr_i, img, used;
    logic [7:2]  port_e_data_i, port_e_direction_i, pin_i, pin_o, pin_oe_o;
    logic [31:0] dat_i, dat_o, q;
    logic [31:0] lfsr = 32'h87585186;
    integer      fail_count, comparisons;

    port_e_function_assignment u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .mode_i, .bus_clock_stretch_ctl_i, .tag_enable_i, .free_cycle_i, .queue_state_i,
        .low_byte_strobe_i, .read_write_i, .port_e_data_i, .port_e_direction_i, .pin_i, .pin_o, .pin_oe_o,
        .low_tag_input_o);
    port_e_far_side u_far (.pin_o, .pin_oe_o, .tag_drive_i(tag_enable_i), .tag_val_i(tag_val), .pin_i);

    function automatic logic [31:0] nxt(input logic [31:0] s);
        nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // reset image of the select register per mode
    function automatic logic [7:0] rst_img(input logic [2:0] m);
        case (m)
            3'h1, 3'h3: rst_img = 8'hAC;
            3'h2:       rst_img = 8'h2C;
            3'h4:       rst_img = 8'h10;
            default:    rst_img = 8'h00;
        endcase
    endfunction

    task close_out;
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one classic cycle; waits for ack under a bound
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        integer n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h000000, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) begin
            n = n + 1;
            if (n > 16) begin
                fail_count = fail_count + 1;
                close_out();
            end
            @(posedge clk_i);
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // write policy: never in emulation, anytime in special, once in normal except bit 4 anytime
    task automatic mdl_wr(input logic [2:0] m, input logic [7:0] d);
        for (int b = 2; b < 8; b++) begin
            if (b == 6 || m == 3'h1 || m == 3'h3)
                continue;
            if (b == 4 || !m[2] || m == 3'h6 || !used[b])
                img[b] = d[b];
            if (m[2] && m != 3'h6)
                used[b] = 1'b1;
        end
    endtask

    task automatic run_mode(input logic [2:0] m);
        logic [7:0] r;
        logic [3:0] s;
        logic       fx;
        logic [7:2] eo, mk;
        rst_i <= 1'b1;
        mode_i <= m;
        tag_enable_i <= (m == 3'h2);
        tag_val <= lfsr[11]; // tag source held steady for the whole mode
        port_e_direction_i <= lfsr[17:12];
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        img = rst_img(m);
        used = 8'h00;
        bus(1'b0, 8'h28, 8'h00, 4'hF);
        chk("reset image", q, {24'h0, img});
        // three random select writes, the last with byte lane 0 off, each read back
        for (int k = 0; k < 3; k++) begin
            r = lfsr[7:0];
            s = (k == 2) ? 4'hE : 4'hF;
            bus(1'b1, 8'h28, r, s);
            if (s[0])
                mdl_wr(m, r);
            bus(1'b0, 8'h28, 8'h00, 4'hF);
            chk("select", q, {24'h0, img});
        end
        bus(1'b0, 8'h30, 8'h00, 4'hF);
        chk("unmapped", q, 32'h00000000);
        bus(1'b0, 8'h2C, 8'h00, 4'hF);
        chk("status", q, {25'h0, m, ((m == 3'h1 || m == 3'h3) ? 4'h0 : 4'hF)});
        if (m == 3'h2)
            chk("low tag", {31'h0, low_tag_input_o}, {31'h0, tag_val});
        fx = (m != 3'h0) && (m != 3'h4) && (m != 3'h6);
        eo = port_e_direction_i | {fx & ~img[7], fx & img[5], fx & img[5], ~img[4], fx & (m != 3'h5) & img[3],
            fx & img[2]};
        mk = (m == 3'h2) ? 6'h3D : 6'h3F;
        chk("pin enables", {26'h0, pin_oe_o & mk}, {26'h0, eo & mk});
    endtask

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // core status and port data wander every cycle
    always @(posedge clk_i) begin
        lfsr <= nxt(lfsr);
        free_cycle_i <= lfsr[0];
        queue_state_i <= lfsr[2:1];
        read_write_i <= lfsr[3];
        low_byte_strobe_i <= lfsr[4];
        port_e_data_i <= lfsr[10:5];
    end

    initial begin
        fail_count = 0;
        comparisons = 0;
        {rst_i, cyc_i, stb_i, we_i, bus_clock_stretch_ctl_i, tag_enable_i, tag_val} = 7'h01 << 6;
        mode_i = 3'h0;
        adr_i = 8'h00;
        sel_i = 4'h0;
        dat_i = 32'h00000000;
        port_e_direction_i = 6'h00;
        for (int m = 0; m < 8; m++)
            run_mode(m[2:0]);
        close_out();
    end
endmodule
